// [hdl/mp_router_pkg.sv]
// package: register map, field layout, reset values and selector codes of the pin router
package mp_router_pkg;
   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_ROUTE_CTRL = 8'h00;
   localparam logic [7:0] OFF_FLAG_CHOICE = 8'h04;
   localparam logic [7:0] OFF_GPIO_DRIVE = 8'h08;
   localparam logic [7:0] OFF_GPIO_VALUE = 8'h0c;
   localparam logic [7:0] OFF_A_TRISTATE = 8'h10;
   localparam logic [7:0] OFF_PIN_STATUS = 8'h14;

   // ---------------------------------------------------------------
   // route control and pin status field positions
   // ---------------------------------------------------------------
   localparam int A_SEL_LSB = 0;
   localparam int B_SEL_LSB = 2;
   localparam int C_SEL_LSB = 5;
   localparam int MC_EN_BIT = 8;
   localparam int MC_SRC_LSB = 9;
   localparam int ADC_SLAVE_BIT = 11;
   localparam int RX_SEL_LSB = 16;
   localparam int LOCK_STATUS_BIT = 16;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [1:0] A_SEL_RST = 2'h1;
   localparam logic [2:0] B_SEL_RST = 3'h0;
   localparam logic [2:0] C_SEL_RST = 3'h0;
   localparam logic [1:0] MC_SRC_RST = 2'h0;
   localparam logic ADC_SLAVE_RST = 1'b1;
   localparam logic [3:0] RX_SEL_RST = 4'h2;
   localparam logic [3:0] A_TRI_RST = 4'hf;
   localparam logic [11:0] CHOICE_RST = 12'h000;

   // ---------------------------------------------------------------
   // group selector codes
   // ---------------------------------------------------------------
   localparam logic [1:0] A_BIPHASE_IN = 2'h0;
   localparam logic [1:0] A_STATUS_OUT = 2'h1;
   localparam logic [1:0] A_SEC_CLOCKS = 2'h2;
   localparam logic [1:0] A_FLAG_GPIO = 2'h3;
   localparam logic [2:0] BC_AUX_IN = 3'h0;
   localparam logic [2:0] BC_PORT_1 = 3'h1;
   localparam logic [2:0] BC_RATE_CODE = 3'h2;
   localparam logic [2:0] BC_FLAG_GPIO = 3'h3;
   localparam logic [2:0] BC_BLOCK_BITS = 3'h4;
   localparam logic [2:0] BC_PORT_5 = 3'h5;
endpackage : mp_router_pkg

// [hdl/pin_sync.sv]
// two-flop synchroniser for pin levels entering the core clock domain
module pin_sync #(
   parameter int WIDTH = 12
) (
   input wire logic i_clk,               // core clock
   input wire logic i_rstn,              // synchronous reset, active low
   input wire logic [WIDTH-1:0] i_async, // raw pin levels
   output logic [WIDTH-1:0] o_sync       // synchronised levels
);
   logic [WIDTH-1:0] meta_q;

   // the first stage feeds only the second stage
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         meta_q <= '0;
         o_sync <= '0;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule // pin_sync

// [hdl/router_regs.sv]
// AHB-Lite register slave holding the routing configuration
module router_regs
   import mp_router_pkg::*;
(
   input wire logic i_clk,                 // core clock
   input wire logic i_rstn,                // synchronous reset, active low
   input wire logic i_hsel,                // slave select
   input wire logic [7:0] i_haddr,         // byte address
   input wire logic [1:0] i_htrans,        // transfer type
   input wire logic i_hwrite,              // write when high
   input wire logic i_hready,              // bus ready
   input wire logic [31:0] i_hwdata,       // write data
   input wire logic [11:0] i_pin_levels,   // synchronised pin levels
   input wire logic i_rx_lock,             // receiver lock
   output logic [31:0] o_hrdata,           // read data
   output logic o_hreadyout,               // always ready
   output logic [31:0] o_route_ctrl,       // route control value
   output logic [11:0] o_choice,           // flag(1) or gpio(0) per pin
   output logic [11:0] o_gpio_drive,       // gpio drive enable per pin
   output logic [11:0] o_gpio_value,       // gpio output level per pin
   output logic [3:0] o_a_tristate         // group a per-pin tristate
);
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic [31:0] ctrl_q, ctrl_d;
   logic [11:0] choice_q, choice_d, drive_q, drive_d, value_q, value_d;
   logic [3:0] atri_q, atri_d;
   wire take = i_hsel & i_hready & i_htrans[1];
   wire [31:0] ctrl_mask = 32'h000f_0fff;

   function automatic logic wr_hit(input logic [7:0] off);
      return wr_pend_q && (wr_addr_q == off);
   endfunction

   assign ctrl_d = wr_hit(OFF_ROUTE_CTRL) ? (i_hwdata & ctrl_mask) : ctrl_q;
   assign choice_d = wr_hit(OFF_FLAG_CHOICE) ? i_hwdata[11:0] : choice_q;
   assign drive_d = wr_hit(OFF_GPIO_DRIVE) ? i_hwdata[11:0] : drive_q;
   assign value_d = wr_hit(OFF_GPIO_VALUE) ? i_hwdata[11:0] : value_q;
   assign atri_d = wr_hit(OFF_A_TRISTATE) ? i_hwdata[3:0] : atri_q;

   // ---------------------------------------------------------------
   // read mux looks at next values so a read right after a write sees it
   // ---------------------------------------------------------------
   wire [31:0] rd_mux =
      (i_haddr == OFF_ROUTE_CTRL) ? ctrl_d :
      (i_haddr == OFF_FLAG_CHOICE) ? {20'h0, choice_d} :
      (i_haddr == OFF_GPIO_DRIVE) ? {20'h0, drive_d} :
      (i_haddr == OFF_GPIO_VALUE) ? {20'h0, value_d} :
      (i_haddr == OFF_A_TRISTATE) ? {28'h0, atri_d} :
      (i_haddr == OFF_PIN_STATUS) ? {15'h0, i_rx_lock, 4'h0, i_pin_levels} : 32'h0;

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         o_hrdata <= 32'h0;
         o_hreadyout <= 1'b1;
      end else begin
         wr_pend_q <= take & i_hwrite;
         wr_addr_q <= i_haddr;
         o_hrdata <= (take & ~i_hwrite) ? rd_mux : 32'h0;
         // no wait states; kept in a flop so the bus sees a clean output
         o_hreadyout <= 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         ctrl_q <= {12'h0, RX_SEL_RST, 4'h0, ADC_SLAVE_RST, MC_SRC_RST, 1'b0,
                    C_SEL_RST, B_SEL_RST, A_SEL_RST};
         choice_q <= CHOICE_RST;
         drive_q <= 12'h000;
         value_q <= 12'h000;
         atri_q <= A_TRI_RST;
      end else begin
         ctrl_q <= ctrl_d;
         choice_q <= choice_d;
         drive_q <= drive_d;
         value_q <= value_d;
         atri_q <= atri_d;
      end
   end

   assign o_route_ctrl = ctrl_q;
   assign o_choice = choice_q;
   assign o_gpio_drive = drive_q;
   assign o_gpio_value = value_q;
   assign o_a_tristate = atri_q;
endmodule // router_regs

// [hdl/mp_pin_router.sv]
// multipurpose pin router: three four-pin groups, main port and multichannel mode
// Notes on behaviour
// - group a code: 00 biphase in, 01 status/validity/xtal/int, 10 sec clocks, 11 flag/gpio
// - group b code: aux in2, aux out, rate code, flag/gpio, block bits, ext converter
// - group c code: aux in1, converter port, rate code, flag/gpio, block bits, tx in
// - group a pins float after reset, each through its own tristate bit
// - converter runs as crystal-timed clock slave after reset
// - receiver takes biphase input two after reset
// - main port carries converter until receiver locks, then receiver data
// - writing one to multichannel enable turns on eight-channel routing
// - multichannel enable overrides all three group selectors
// - multichannel: groups a and c are inputs plus clock transient output
// - multichannel: group b and main port are outputs; main data equals output 0
// - source 00/10: main source on clocks, data, output 0; outputs 1-3 low
// - source 01/11: multichannel input clocks, inputs 0-3 onto outputs 0-3
// - main source is receiver clocks and data, or converter data and clocks
//
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
module mp_pin_router
   import mp_router_pkg::*;
(
   input wire logic I_CORE_CLK,            // core clock, 20 MHz
   input wire logic I_RSTN,                // synchronous reset, active low
   input wire logic I_HSEL,                // ahb select
   input wire logic [7:0] I_HADDR,         // ahb address
   input wire logic [1:0] I_HTRANS,        // ahb transfer type
   input wire logic I_HWRITE,              // ahb write
   input wire logic [2:0] I_HSIZE,         // ahb size, word only
   input wire logic I_HREADY,              // ahb ready in
   input wire logic [31:0] I_HWDATA,       // ahb write data
   output logic [31:0] O_HRDATA,           // ahb read data
   output logic O_HREADYOUT,               // ahb ready out
   output logic O_HRESP,                   // ahb response, okay
   input wire logic [3:0] I_MPA_IN,        // group a pin levels
   input wire logic [3:0] I_MPB_IN,        // group b pin levels
   input wire logic [3:0] I_MPC_IN,        // group c pin levels
   output logic [3:0] O_MPA_OUT,           // group a drive level
   output logic [3:0] O_MPA_OE_N,          // group a enable, low drives
   output logic [3:0] O_MPB_OUT,           // group b drive level
   output logic [3:0] O_MPB_OE_N,          // group b enable, low drives
   output logic [3:0] O_MPC_OUT,           // group c drive level
   output logic [3:0] O_MPC_OE_N,          // group c enable, low drives
   input wire logic I_CLOCK_TRANSIENT_STATUS, // receiver clock transient
   input wire logic I_VALIDITY_BIT_OUT,    // receiver validity bit
   input wire logic I_CRYSTAL_CLOCK,       // crystal clock for buffering
   input wire logic I_INTERRUPT_ZERO,      // interrupt system 0
   input wire logic I_SECONDARY_BIT_CLOCK, // secondary bit clock
   input wire logic I_SECONDARY_LR_CLOCK,  // secondary lr clock
   input wire logic [3:0] I_RATE_CODE,     // sampling-rate code bits
   input wire logic I_BLOCK_START,         // block start bit
   input wire logic I_CHANNEL_STATUS_BIT,  // channel status bit
   input wire logic I_USER_BIT,            // user bit
   input wire logic [11:0] I_FLAG,         // per-pin flag source, c b a
   input wire logic [3:0] I_AUX_OUT,       // aux output clocks and data
   input wire logic [2:0] I_EXT_CONV_CLKS, // ext converter sys, bit, lr clock
   input wire logic I_CONV_DATA,           // standalone converter data
   input wire logic I_RX_LOCK,             // receiver lock
   input wire logic [3:0] I_RX_PORT,       // receiver sck, bck, lrck, data
   input wire logic [3:0] I_ADC_PORT,      // converter sck, bck, lrck, data
   output logic [3:0] O_MAIN_PORT,         // main port sck, bck, lrck, data
   output logic [3:0] O_BIPHASE_IN,        // biphase inputs eight to eleven
   output logic [3:0] O_AUX_IN2,           // aux input 2 clocks and data
   output logic [3:0] O_AUX_IN1,           // aux input 1 clocks and data
   output logic O_EXT_CONV_DATA,           // ext converter data in
   output logic [2:0] O_CONV_PORT_IN,      // standalone converter clocks in
   output logic [3:0] O_TX_PORT_IN,        // standalone transmitter inputs
   output logic O_ADC_CLOCK_SLAVE,         // converter as crystal clock slave
   output logic [3:0] O_RX_INPUT_SELECT    // receiver biphase input number
);
   logic [11:0] pins;
   logic [31:0] ctrl;
   logic [11:0] choice, gdrive, gvalue;
   logic [3:0] atri;

   // ---------------------------------------------------------------
   // bus slave and pin synchroniser
   // ---------------------------------------------------------------
   pin_sync #(.WIDTH(12)) u_sync (
      .i_clk(I_CORE_CLK),
      .i_rstn(I_RSTN),
      .i_async({I_MPC_IN, I_MPB_IN, I_MPA_IN}),
      .o_sync(pins)
   );

   router_regs u_regs (
      .i_clk(I_CORE_CLK),
      .i_rstn(I_RSTN),
      .i_hsel(I_HSEL),
      .i_haddr(I_HADDR),
      .i_htrans(I_HTRANS),
      .i_hwrite(I_HWRITE),
      .i_hready(I_HREADY),
      .i_hwdata(I_HWDATA),
      .i_pin_levels(pins),
      .i_rx_lock(I_RX_LOCK),
      .o_hrdata(O_HRDATA),
      .o_hreadyout(O_HREADYOUT),
      .o_route_ctrl(ctrl),
      .o_choice(choice),
      .o_gpio_drive(gdrive),
      .o_gpio_value(gvalue),
      .o_a_tristate(atri)
   );

   // ---------------------------------------------------------------
   // decoded configuration
   // ---------------------------------------------------------------
   wire [1:0] a_sel = ctrl[A_SEL_LSB +: 2];
   wire [2:0] b_sel = ctrl[B_SEL_LSB +: 3];
   wire [2:0] c_sel = ctrl[C_SEL_LSB +: 3];
   wire mc_en = ctrl[MC_EN_BIT];
   wire [1:0] mc_src = ctrl[MC_SRC_LSB +: 2];
   wire mc_pass = mc_en & mc_src[0];
   wire [3:0] pa = pins[3:0];
   wire [3:0] pb = pins[7:4];
   wire [3:0] pc = pins[11:8];

   // flag or gpio per pin: out level and active-high drive
   function automatic logic [7:0] flag_gpio(input logic [3:0] ch, input logic [3:0] fl,
                                             input logic [3:0] dr, input logic [3:0] va);
      return {(ch | dr), (ch & fl) | (~ch & va)};
   endfunction

   // ---------------------------------------------------------------
   // main output source and multichannel outputs
   // ---------------------------------------------------------------
   // converter holds the main port until the receiver locks
   wire [3:0] main_src = I_RX_LOCK ? I_RX_PORT : I_ADC_PORT;
   // multichannel input: c0..c2 clocks, c3 input 0, a0..a2 inputs 1..3
   wire [3:0] mc_in_port = pc;
   wire [3:0] main_d = mc_pass ? mc_in_port : main_src;
   wire [3:0] mdout_d = mc_pass ? {pa[2:0], pc[3]} : {3'b000, main_src[3]};

   // ---------------------------------------------------------------
   // group a
   // ---------------------------------------------------------------
   wire [7:0] a_fg = flag_gpio(choice[3:0], I_FLAG[3:0], gdrive[3:0], gvalue[3:0]);
   wire [3:0] a_out_n =
      (a_sel == A_STATUS_OUT) ? {I_INTERRUPT_ZERO, I_CRYSTAL_CLOCK, I_VALIDITY_BIT_OUT,
                                 I_CLOCK_TRANSIENT_STATUS} :
      (a_sel == A_SEC_CLOCKS) ? {I_INTERRUPT_ZERO, I_CRYSTAL_CLOCK, I_SECONDARY_LR_CLOCK,
                                 I_SECONDARY_BIT_CLOCK} :
      (a_sel == A_FLAG_GPIO) ? a_fg[3:0] : 4'h0;
   wire [3:0] a_drv_n =
      (a_sel == A_BIPHASE_IN) ? 4'h0 :
      (a_sel == A_FLAG_GPIO) ? a_fg[7:4] : 4'hf;
   // each pin floats while its own tristate bit is set
   wire [3:0] a_out_d = mc_en ? {I_CLOCK_TRANSIENT_STATUS, 3'b000} : a_out_n;
   wire [3:0] a_drv_d = (mc_en ? 4'b1000 : a_drv_n) & ~atri;

   // ---------------------------------------------------------------
   // group b
   // ---------------------------------------------------------------
   wire [7:0] b_fg = flag_gpio(choice[7:4], I_FLAG[7:4], gdrive[7:4], gvalue[7:4]);
   wire [3:0] b_out_n =
      (b_sel == BC_PORT_1) ? I_AUX_OUT :
      (b_sel == BC_RATE_CODE) ? {I_RATE_CODE[0], I_RATE_CODE[1], I_RATE_CODE[2],
                                 I_RATE_CODE[3]} :
      (b_sel == BC_FLAG_GPIO) ? b_fg[3:0] :
      (b_sel == BC_BLOCK_BITS) ? {I_VALIDITY_BIT_OUT, I_USER_BIT, I_CHANNEL_STATUS_BIT,
                                  I_BLOCK_START} :
      (b_sel == BC_PORT_5) ? {1'b0, I_EXT_CONV_CLKS} : 4'h0;
   // reserved and test codes drive nothing
   wire [3:0] b_drv_n =
      (b_sel == BC_AUX_IN) ? 4'h0 :
      (b_sel == BC_FLAG_GPIO) ? b_fg[7:4] :
      (b_sel == BC_PORT_5) ? 4'h7 :
      (b_sel[2:1] == 2'b11) ? 4'h0 : 4'hf;
   wire [3:0] b_out_d = mc_en ? mdout_d : b_out_n;
   wire [3:0] b_drv_d = mc_en ? 4'hf : b_drv_n;

   // ---------------------------------------------------------------
   // group c
   // ---------------------------------------------------------------
   wire [7:0] c_fg = flag_gpio(choice[11:8], I_FLAG[11:8], gdrive[11:8], gvalue[11:8]);
   wire [3:0] c_out_n =
      (c_sel == BC_PORT_1) ? {I_CONV_DATA, 3'b000} :
      (c_sel == BC_RATE_CODE) ? {I_RATE_CODE[0], I_RATE_CODE[1], I_RATE_CODE[2],
                                 I_RATE_CODE[3]} :
      (c_sel == BC_FLAG_GPIO) ? c_fg[3:0] :
      (c_sel == BC_BLOCK_BITS) ? {I_VALIDITY_BIT_OUT, I_USER_BIT, I_CHANNEL_STATUS_BIT,
                                  I_BLOCK_START} : 4'h0;
   wire [3:0] c_drv_n =
      (c_sel == BC_PORT_1) ? 4'h8 :
      (c_sel == BC_RATE_CODE) ? 4'hf :
      (c_sel == BC_FLAG_GPIO) ? c_fg[7:4] :
      (c_sel == BC_BLOCK_BITS) ? 4'hf : 4'h0;
   wire [3:0] c_out_d = mc_en ? 4'h0 : c_out_n;
   wire [3:0] c_drv_d = mc_en ? 4'h0 : c_drv_n;

   // ---------------------------------------------------------------
   // inbound routing toward the internal blocks
   // ---------------------------------------------------------------
   wire a_in = ~mc_en & (a_sel == A_BIPHASE_IN);
   wire b_aux = ~mc_en & (b_sel == BC_AUX_IN);
   wire b_ext = ~mc_en & (b_sel == BC_PORT_5);
   wire c_aux = ~mc_en & (c_sel == BC_AUX_IN);
   wire c_conv = ~mc_en & (c_sel == BC_PORT_1);
   wire c_tx = ~mc_en & (c_sel == BC_PORT_5);

   // ---------------------------------------------------------------
   // output registers: pins change one edge after the decode
   // ---------------------------------------------------------------
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RSTN) begin
         O_MPA_OUT <= 4'h0;
         O_MPA_OE_N <= 4'hf;
         O_MPB_OUT <= 4'h0;
         O_MPB_OE_N <= 4'hf;
         O_MPC_OUT <= 4'h0;
         O_MPC_OE_N <= 4'hf;
         O_MAIN_PORT <= 4'h0;
      end else begin
         O_MPA_OUT <= a_out_d;
         O_MPA_OE_N <= ~a_drv_d;
         O_MPB_OUT <= b_out_d;
         O_MPB_OE_N <= ~b_drv_d;
         O_MPC_OUT <= c_out_d;
         O_MPC_OE_N <= ~c_drv_d;
         O_MAIN_PORT <= main_d;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RSTN) begin
         O_BIPHASE_IN <= 4'h0;
         O_AUX_IN2 <= 4'h0;
         O_AUX_IN1 <= 4'h0;
         O_EXT_CONV_DATA <= 1'b0;
         O_CONV_PORT_IN <= 3'h0;
         O_TX_PORT_IN <= 4'h0;
         O_ADC_CLOCK_SLAVE <= ADC_SLAVE_RST;
         O_RX_INPUT_SELECT <= RX_SEL_RST;
         O_HRESP <= 1'b0;
      end else begin
         O_BIPHASE_IN <= a_in ? pa : 4'h0;
         O_AUX_IN2 <= b_aux ? pb : 4'h0;
         O_AUX_IN1 <= c_aux ? pc : 4'h0;
         O_EXT_CONV_DATA <= b_ext & pb[3];
         O_CONV_PORT_IN <= c_conv ? pc[2:0] : 3'h0;
         O_TX_PORT_IN <= c_tx ? pc : 4'h0;
         O_ADC_CLOCK_SLAVE <= ctrl[ADC_SLAVE_BIT];
         O_RX_INPUT_SELECT <= ctrl[RX_SEL_LSB +: 4];
         O_HRESP <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_tristate_float: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (atri == 4'hf) |=> (O_MPA_OE_N == 4'hf))
      else $error("group a pin drives while its tristate bit is set");

   a_biphase_in: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (!mc_en && a_sel == A_BIPHASE_IN) |=> (O_MPA_OE_N == 4'hf) && (O_BIPHASE_IN == $past(pa)))
      else $error("group a biphase input routing wrong");

   a_mc_override: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (mc_en && b_sel == BC_AUX_IN) |=> (O_MPB_OE_N == 4'h0) && (O_AUX_IN2 == 4'h0))
      else $error("group b selector not overridden in multichannel mode");

   a_mdout_low: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (mc_en && !mc_src[0]) |=> (O_MPB_OUT[3:1] == 3'b000) && (O_MPB_OUT[0] == O_MAIN_PORT[3]))
      else $error("multichannel outputs 1-3 not low for main source");

   a_mdin_pass: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
      mc_pass |=> (O_MPB_OUT == {$past(pa[2:0]), $past(pc[3])}) && (O_MAIN_PORT == $past(pc)))
      else $error("multichannel inputs not passed to outputs");

   a_main_lock: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (!mc_pass && I_RX_LOCK) ##1 (!mc_pass && !I_RX_LOCK)
         |-> (O_MAIN_PORT == $past(I_RX_PORT)) ##1 (O_MAIN_PORT == $past(I_ADC_PORT)))
      else $error("main port source does not follow receiver lock");

   a_reserved_hiz: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (!mc_en && b_sel[2:1] == 2'b11 && c_sel[2:1] == 2'b11)
         |=> (O_MPB_OE_N == 4'hf) && (O_MPC_OE_N == 4'hf))
      else $error("reserved selector code drives a pin");

   a_conv_port: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (!mc_en && c_sel == BC_PORT_1)
         |=> (O_MPC_OE_N == 4'b0111) && (O_MPC_OUT[3] == $past(I_CONV_DATA)))
      else $error("converter port routing on group c wrong");

   a_select_live: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (!mc_en && $changed(b_sel) && b_sel == BC_BLOCK_BITS) |=> (O_MPB_OE_N == 4'h0))
      else $error("selector change not applied on the next edge");
endmodule // mp_pin_router

// [verif/pin_partner.sv]
// far-side model: drives each multipurpose pin wherever the router releases it
module pin_partner (
   input wire logic [11:0] i_out,  // router drive level
   input wire logic [11:0] i_oe_n, // router enable, low drives
   input wire logic [11:0] i_ext,  // far-side pattern, changes each scenario
   output logic [11:0] o_pin       // resolved pin level
);
   timeunit 1ns;
   timeprecision 1ns;
   // a released pin shows the far side, never a stale router level
   assign o_pin = (~i_oe_n & i_out) | (i_oe_n & i_ext);
endmodule // pin_partner

// [verif/testbench.sv]
// self-checking bench of the multipurpose pin router
module testbench;
   import mp_router_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rstn = 0, hsel = 0, hwrite = 0;
   logic [7:0] haddr = 0;
   logic [1:0] htrans = 0;
   logic [31:0] hwdata = 0, rd, hrdata;
   logic [63:0] rn = 0;
   logic [11:0] pin;
   logic [3:0] ao, ae, bo, be, co, ce, mp, bi, a2, a1, tx, rxs, m;
   logic hro, hrs, ecd, acs;
   logic [2:0] cpi;
   int seed = 32'hda220d15;
   int failures = 0, n_tests = 0;
   initial forever #25 clk = ~clk;
   pin_partner far (.i_out({co, bo, ao}), .i_oe_n({ce, be, ae}), .i_ext(rn[52:41]), .o_pin(pin));
   mp_pin_router dut (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_HSEL(hsel), .I_HADDR(haddr),
      .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HREADY(hro), .I_HWDATA(hwdata),
      .O_HRDATA(hrdata), .O_HREADYOUT(hro), .O_HRESP(hrs), .I_MPA_IN(pin[3:0]),
      .I_MPB_IN(pin[7:4]), .I_MPC_IN(pin[11:8]), .O_MPA_OUT(ao), .O_MPA_OE_N(ae),
      .O_MPB_OUT(bo), .O_MPB_OE_N(be), .O_MPC_OUT(co), .O_MPC_OE_N(ce),
      .I_CLOCK_TRANSIENT_STATUS(rn[0]), .I_VALIDITY_BIT_OUT(rn[1]), .I_CRYSTAL_CLOCK(rn[2]),
      .I_INTERRUPT_ZERO(rn[3]), .I_SECONDARY_BIT_CLOCK(rn[4]), .I_SECONDARY_LR_CLOCK(rn[5]),
      .I_RATE_CODE(rn[9:6]), .I_BLOCK_START(rn[10]), .I_CHANNEL_STATUS_BIT(rn[11]),
      .I_USER_BIT(rn[12]), .I_FLAG(rn[24:13]), .I_AUX_OUT(rn[28:25]), .I_EXT_CONV_CLKS(rn[31:29]),
      .I_CONV_DATA(rn[32]), .I_RX_LOCK(rn[53]), .I_RX_PORT(rn[36:33]), .I_ADC_PORT(rn[40:37]),
      .O_MAIN_PORT(mp), .O_BIPHASE_IN(bi), .O_AUX_IN2(a2), .O_AUX_IN1(a1),
      .O_EXT_CONV_DATA(ecd), .O_CONV_PORT_IN(cpi), .O_TX_PORT_IN(tx),
      .O_ADC_CLOCK_SLAVE(acs), .O_RX_INPUT_SELECT(rxs));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %s exp %h got %h", nm, e, s);
      end
   endtask
   // request held until hready, read data taken in its data phase
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
      do @(posedge clk); while (hro !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do @(posedge clk); while (hro !== 1'b1);
      rd = hrdata;
   endtask
   // pin inputs need three edges: two to synchronise, one to register
   task automatic cfg(input logic [31:0] v);
      rn <= {$random(seed), $random(seed)};
      xfer(1'b1, OFF_ROUTE_CTRL, v);
      repeat (5) @(posedge clk);
   endtask
   function automatic logic [7:0] ea(logic [1:0] k);
      if (k == 2'h1) return {4'h0, rn[3], rn[2], rn[1], rn[0]};
      if (k == 2'h2) return {4'h0, rn[3], rn[2], rn[5], rn[4]};
      return 8'hff;
   endfunction
   function automatic logic [7:0] ebc(logic [2:0] k, logic c);
      case (k)
         3'h1: return c ? {4'h7, rn[32], 3'h7} : {4'h0, rn[28:25]};
         3'h2: return {4'h0, rn[6], rn[7], rn[8], rn[9]};
         3'h3: return c ? 8'hcd : {4'h0, rn[20:17]};
         3'h4: return {4'h0, rn[1], rn[12], rn[11], rn[10]};
         3'h5: return c ? 8'hff : {4'h8, 1'b1, rn[31:29]};
         default: return 8'hff;
      endcase
   endfunction
   task automatic wrap_up();
      $display("tests %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #(3000 * 50);
      failures++;
      wrap_up();
   end
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      xfer(1'b0, OFF_ROUTE_CTRL, 0);
      chk("ctrl", 32'h0002_0801, rd);
      chk("cfg", 5'h12, {acs, rxs});
      chk("a_oe", 4'hf, ae);
      xfer(1'b0, 8'h40, 0);
      chk("unmapped", 0, rd);
      chk("hresp", 0, hrs);
      xfer(1'b1, OFF_A_TRISTATE, 0);
      xfer(1'b1, OFF_FLAG_CHOICE, 32'h0f0);
      xfer(1'b1, OFF_GPIO_DRIVE, 32'h300);
      xfer(1'b1, OFF_GPIO_VALUE, 32'h100);
      for (int k = 0; k < 8; k++) begin
         cfg(32'h800 | {k[2:0], k[2:0], k[1:0]});
         chk("main", rn[53] ? rn[36:33] : rn[40:37], mp);
         chk("mpa", ea(k[1:0]), {ae, ao | ae});
         chk("mpb", ebc(k[2:0], 1'b0), {be, bo | be});
         chk("mpc", ebc(k[2:0], 1'b1), {ce, co | ce});
         chk("ins", {rn[48] & (k == 5), (k == 1) ? rn[51:49] : 3'h0, (k == 5) ? rn[52:49] : 4'h0,
            (k == 0) ? rn[52:45] : 8'h0, (k[1:0] == 0) ? rn[44:41] : 4'h0},
            {ecd, cpi, tx, a1, a2, bi});
      end
      for (int s = 0; s < 4; s++) begin
         cfg((s[1] ? 32'h94a : 32'h900) | (s << 9));
         m = s[0] ? rn[52:49] : (rn[53] ? rn[36:33] : rn[40:37]);
         chk("mc_main", m, mp);
         chk("mc_b", {4'h0, s[0] ? {rn[43:41], rn[52]} : {3'h0, m[3]}}, {be, bo});
         chk("mc_ac", {4'h7, rn[0], 3'h7, 8'hff}, {ae, ao | ae, ce, co | ce});
         chk("mc_ins", 0, {a1, a2, bi});
      end
      wrap_up();
   end
endmodule // testbench
